// ### verilog/sdm_pkg.sv
// constants, opcodes and types for the serial dot matrix display controller
// assumes a single 100 MHz mclk domain shared by all logic
package sdm_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_HALF_NS = 2000;
  localparam int OSC_HALF_CYC = (OSC_HALF_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam logic [8:0] STROBE_LAST = 9'h13F;  // divide by 320
  localparam logic [3:0] PRESCALE_LAST = 4'hF;  // divide by 16
  // ==========================================================
  // geometry
  localparam int NUM_CHARS = 8;
  localparam int NUM_ROWS = 7;
  localparam int NUM_COLS = 5;
  localparam int RAM_WORDS = 56;
  localparam logic [2:0] LAST_ROW = 3'h6;
  localparam logic [2:0] ROW_DONE = 3'h7;
  // ==========================================================
  // command words
  localparam logic [2:0] OPC_ADDR = 3'h5;
  localparam logic [2:0] OPC_COLUMN = 3'h0;
  localparam logic [2:0] OPC_CTRL = 3'h7;
  localparam logic [7:0] CLEAR_WORD = 8'hC0;
  localparam int CTL_PRESCALE_BIT = 4;
  localparam int CTL_PEAK_BIT = 3;
  localparam logic [4:0] CTL_RESET = 5'h08;  // 100 %, full peak, /1
  localparam logic [4:0] CTL_POWER_DOWN = 5'h0F;
  // on-time per row in mux ticks out of 320, indexed by brightness code
  localparam logic [8:0] DUTY_TABLE [0:7] = '{9'h140, 9'h0AA, 9'h080,
    9'h056, 9'h040, 9'h02A, 9'h015, 9'h000};
  // ==========================================================
  // apb map and status layout
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam int ST_CHAR_LSB = 0;
  localparam int ST_ROWPTR_LSB = 3;
  localparam int ST_CTL_LSB = 6;
  localparam int ST_CLEAR_BIT = 11;
  localparam int ST_PDOWN_BIT = 12;
  localparam int ST_INTOSC_BIT = 13;
  // ==========================================================
  // decoded command kinds
  typedef enum logic [4:0] {
    SDM_OP_NONE = 5'b00001,
    SDM_OP_ADDR = 5'b00010,
    SDM_OP_COLUMN = 5'b00100,
    SDM_OP_CTRL = 5'b01000,
    SDM_OP_CLEAR = 5'b10000
  } sdm_op_t;
endpackage

// ### verilog/sdm_display_ctrl.sv
// serial command interpreter, dot ram and row multiplexer
// assumes a host shifting words on pins, and an apb master on mclk
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module sdm_display_ctrl (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic serial_data,
  input wire logic serial_shift_clock,
  input wire logic load_n,
  input wire logic clock_source_select,
  input wire logic mux_clk_in,
  output logic mux_clk_out,
  output logic mux_clk_oe,
  output logic [6:0] row_strobe,
  output logic [39:0] column_drive,
  output logic peak_current_full,
  output logic power_down,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ========================================================
  // pin synchronisers: data, shift clock, load, select, mux clock
  logic [4:0] sync1, sync2, sync3, filt;
  logic [4:0] next_filt;
  logic f_data, f_sclk, f_load_n, f_sel, f_mclk;
  logic sclk_q, load_q, extclk_q;

  // a pin change counts only once stages two and three agree
  always_comb begin
    next_filt = (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & filt);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync1 <= 5'h04;
      sync2 <= 5'h04;
      sync3 <= 5'h04;
      filt <= 5'h04;
      sclk_q <= 1'b0;
      load_q <= 1'b1;
      extclk_q <= 1'b0;
    end else begin
      sync1 <= {mux_clk_in, clock_source_select, load_n,
                serial_shift_clock, serial_data};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      sclk_q <= f_sclk;
      load_q <= f_load_n;
      extclk_q <= f_mclk;
    end
  end

  assign f_data = filt[0];
  assign f_sclk = filt[1];
  assign f_load_n = filt[2];
  assign f_sel = filt[3];
  assign f_mclk = filt[4];

  // ========================================================
  // serial shift register and command decode
  logic [7:0] shreg, next_shreg, last_cmd, next_last_cmd;
  logic sclk_rise, load_rise, load_fall, apb_cmd;
  logic [7:0] cmd_word;
  logic cmd_valid;
  sdm_pkg::sdm_op_t cmd_op;

  function automatic sdm_pkg::sdm_op_t decode_op(input logic [7:0] w);
    decode_op = sdm_pkg::SDM_OP_NONE;
    if (w == sdm_pkg::CLEAR_WORD) begin
      decode_op = sdm_pkg::SDM_OP_CLEAR;
    end else if (w[7:5] == sdm_pkg::OPC_ADDR && w[4:3] == 2'h0) begin
      decode_op = sdm_pkg::SDM_OP_ADDR;
    end else if (w[7:5] == sdm_pkg::OPC_COLUMN) begin
      decode_op = sdm_pkg::SDM_OP_COLUMN;
    end else if (w[7:5] == sdm_pkg::OPC_CTRL) begin
      decode_op = sdm_pkg::SDM_OP_CTRL;
    end
  endfunction

  assign sclk_rise = f_sclk & ~sclk_q;
  assign load_rise = f_load_n & ~load_q;
  assign load_fall = ~f_load_n & load_q;
  // serial load wins; an apb command in the same cycle is dropped
  assign cmd_valid = load_rise | apb_cmd;
  assign cmd_word = load_rise ? shreg : pwdata[7:0];
  assign cmd_op = cmd_valid ? decode_op(cmd_word)
                            : sdm_pkg::SDM_OP_NONE;

  // lsb first: first bit ends up in bit 0 after eight edges
  always_comb begin
    next_shreg = shreg;
    if (sclk_rise && !f_load_n) begin
      next_shreg = {f_data, shreg[7:1]};
    end
    next_last_cmd = cmd_valid ? cmd_word : last_cmd;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      shreg <= 8'h00;
      last_cmd <= 8'h00;
    end else begin
      shreg <= next_shreg;
      last_cmd <= next_last_cmd;
    end
  end

  // ========================================================
  // address, row pointer, control word, clear and dot ram
  logic [2:0] char_addr, next_char_addr, row_ptr, next_row_ptr;
  logic [4:0] ctl, next_ctl;
  logic clear_act, next_clear_act, blank, next_blank;
  logic [4:0] ram [0:sdm_pkg::RAM_WORDS-1];
  logic [4:0] next_ram [0:sdm_pkg::RAM_WORDS-1];
  logic half_sel;
  logic [5:0] wr_index;

  // half select: bit 2 of the character picks which half owns it
  assign half_sel = char_addr[2];
  // operands widened first so the character base does not wrap at 3 bits
  assign wr_index = 6'(char_addr) * 6'(sdm_pkg::NUM_ROWS) + 6'(row_ptr);

  always_comb begin
    next_char_addr = char_addr;
    next_row_ptr = row_ptr;
    next_ctl = ctl;
    next_clear_act = clear_act;
    next_blank = blank;
    for (int i = 0; i < sdm_pkg::RAM_WORDS; i++) begin
      next_ram[i] = ram[i];
    end
    // the next input cycle ends a clear and lifts the blank
    if (load_fall) begin
      next_clear_act = 1'b0;
      next_blank = 1'b0;
    end
    case (cmd_op)
      sdm_pkg::SDM_OP_ADDR: begin
        next_char_addr = cmd_word[2:0];
        next_row_ptr = 3'h0;
      end
      sdm_pkg::SDM_OP_COLUMN: begin
        if (row_ptr != sdm_pkg::ROW_DONE) begin
          next_ram[wr_index] = {cmd_word[0], cmd_word[1], cmd_word[2],
                                cmd_word[3], cmd_word[4]};
          next_row_ptr = row_ptr + 3'h1;
        end
      end
      sdm_pkg::SDM_OP_CTRL: begin
        next_ctl = cmd_word[4:0];
      end
      sdm_pkg::SDM_OP_CLEAR: begin
        next_clear_act = 1'b1;
        next_blank = 1'b1;
      end
      default: begin
      end
    endcase
    // while clear holds, ram and address stay empty
    if (next_clear_act) begin
      next_char_addr = 3'h0;
      next_row_ptr = 3'h0;
      for (int i = 0; i < sdm_pkg::RAM_WORDS; i++) begin
        next_ram[i] = 5'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      char_addr <= 3'h0;
      row_ptr <= 3'h0;
      ctl <= sdm_pkg::CTL_RESET;
      clear_act <= 1'b0;
      blank <= 1'b1;
      for (int i = 0; i < sdm_pkg::RAM_WORDS; i++) begin
        ram[i] <= 5'h00;
      end
    end else begin
      char_addr <= next_char_addr;
      row_ptr <= next_row_ptr;
      ctl <= next_ctl;
      clear_act <= next_clear_act;
      blank <= next_blank;
      for (int i = 0; i < sdm_pkg::RAM_WORDS; i++) begin
        ram[i] <= next_ram[i];
      end
    end
  end

  // ========================================================
  // mux clock: internal oscillator or pin, prescaler, 320 chain
  logic [7:0] osc_cnt, next_osc_cnt;
  logic osc_q, next_osc_q, mux_tick, src_tick;
  logic [3:0] pre_cnt, next_pre_cnt;
  logic [8:0] phase, next_phase;
  logic [2:0] row, next_row;

  // select high picks the oscillator, low picks the pin
  assign src_tick = f_sel ? (next_osc_q & ~osc_q)
                          : (f_mclk & ~extclk_q);
  assign mux_tick = src_tick && (!ctl[sdm_pkg::CTL_PRESCALE_BIT] ||
                    pre_cnt == sdm_pkg::PRESCALE_LAST);

  // the counter never resets on a clear; only hardware reset stops it
  always_comb begin
    next_osc_cnt = osc_cnt + 8'h01;
    next_osc_q = osc_q;
    if (osc_cnt == 8'(sdm_pkg::OSC_HALF_CYC - 1)) begin
      next_osc_cnt = 8'h00;
      next_osc_q = ~osc_q;
    end
    next_pre_cnt = src_tick ? pre_cnt + 4'h1 : pre_cnt;
    next_phase = phase;
    next_row = row;
    if (mux_tick) begin
      next_phase = phase + 9'h001;
      if (phase == sdm_pkg::STROBE_LAST) begin
        next_phase = 9'h000;
        next_row = (row == sdm_pkg::LAST_ROW) ? 3'h0 : row + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      osc_cnt <= 8'h00;
      osc_q <= 1'b0;
      pre_cnt <= 4'h0;
      phase <= 9'h000;
      row <= 3'h0;
    end else begin
      osc_cnt <= next_osc_cnt;
      osc_q <= next_osc_q;
      pre_cnt <= next_pre_cnt;
      phase <= next_phase;
      row <= next_row;
    end
  end

  // ========================================================
  // display drive: ram read port, duty gating, clock pin
  logic [39:0] next_column;
  logic [6:0] next_strobe;
  logic row_on;

  // duty sets brightness; code 7 gives zero on-time
  assign row_on = (phase < sdm_pkg::DUTY_TABLE[ctl[2:0]]) &&
                  !blank;

  // read side only looks at ram, so writes never stall the scan
  generate
    for (genvar c = 0; c < sdm_pkg::NUM_CHARS; c++) begin : g_col
      assign next_column[c*5 +: 5] = row_on ?
        ram[c * sdm_pkg::NUM_ROWS + int'(row)] : 5'h00;
    end
  endgenerate

  always_comb begin
    next_strobe = row_on ? 7'(7'h01 << row) : 7'h00;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      row_strobe <= 7'h00;
      column_drive <= 40'h00_0000_0000;
      peak_current_full <= 1'b1;
      power_down <= 1'b0;
      mux_clk_out <= 1'b0;
      mux_clk_oe <= 1'b0;
    end else begin
      row_strobe <= next_strobe;
      column_drive <= next_column;
      peak_current_full <= ctl[sdm_pkg::CTL_PEAK_BIT];
      power_down <= (ctl == sdm_pkg::CTL_POWER_DOWN);
      mux_clk_out <= osc_q;
      mux_clk_oe <= f_sel;
    end
  end

  // ========================================================
  // apb slave: one wait-free access phase, errors off the map
  logic [31:0] next_prdata, status;
  logic next_pready, next_pslverr, hit;

  assign hit = (paddr == sdm_pkg::ADDR_STATUS) ||
               (paddr == sdm_pkg::ADDR_CMD);
  assign apb_cmd = psel && penable && pready && pwrite && !pslverr &&
                   (paddr == sdm_pkg::ADDR_CMD);
  assign status = 32'({f_sel, power_down, clear_act, ctl, row_ptr,
                       char_addr});

  always_comb begin
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !hit;
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      next_prdata = (paddr == sdm_pkg::ADDR_CMD) ? 32'(last_cmd)
                  : (paddr == sdm_pkg::ADDR_STATUS) ? status : 32'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_load_blocks_shift: assert property (
    f_load_n |=> shreg == $past(shreg)) else $error("shift while loaded");
  chk_shift_lsb_first: assert property (
    sclk_rise && !f_load_n |=> shreg[7] == $past(f_data))
    else $error("shift bit lost");
  chk_addr_restart: assert property (
    cmd_op == sdm_pkg::SDM_OP_ADDR && !next_clear_act |=>
    row_ptr == 3'h0 && char_addr == $past(cmd_word[2:0]))
    else $error("address load wrong");
  chk_column_store: assert property (
    cmd_op == sdm_pkg::SDM_OP_COLUMN && row_ptr != 3'h7 &&
    !next_clear_act |=> row_ptr == $past(row_ptr) + 3'h1)
    else $error("row pointer stuck");
  chk_ctrl_load: assert property (
    cmd_op == sdm_pkg::SDM_OP_CTRL |=> ctl == $past(cmd_word[4:0]) ##1
    peak_current_full == ctl[3]) else $error("control word lost");
  chk_clear_hold: assert property (
    clear_act && !load_fall |=> clear_act && char_addr == 3'h0)
    else $error("clear released early");
  chk_zero_dark: assert property (
    ctl[2:0] == 3'h7 |=> row_strobe == 7'h00)
    else $error("lit at zero brightness");
  chk_row_advance: assert property (
    mux_tick && phase == 9'h13F |=> row != $past(row) && phase == 9'h000)
    else $error("row did not advance");
  chk_ignore_bad: assert property (
    cmd_valid && cmd_op == sdm_pkg::SDM_OP_NONE && !clear_act |=>
    $stable(ctl) && $stable(char_addr) && $stable(row_ptr))
    else $error("bad opcode changed state");
  chk_clock_pin: assert property (
    f_sel |=> mux_clk_oe) else $error("clock pin not driven");
endmodule

// ### testbench/sdm_host_model.sv
// host serial port model: shifts one word per start pulse, lsb first
// assumes start is a one-cycle pulse and word holds until busy falls
`timescale 1ns/1ps
module sdm_host_model (
  input wire logic mclk,
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] word,
  output logic busy,
  output logic serial_data,
  output logic serial_shift_clock,
  output logic load_n
);
  int i;
  int hold;
  // idle levels: load high, shift clock stands low between frames
  initial begin
    busy = 1'b0;
    serial_data = 1'b0;
    serial_shift_clock = 1'b0;
    load_n = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // ==========================================================
  // frame sender; each level held well past the pin filter depth
  always begin
    @(posedge mclk);
    if (start === 1'b1) begin
      hold = (slow === 1'b1) ? 12 : 6;
      busy <= 1'b1;
      load_n <= 1'b0;
      for (i = 0; i < 8; i++) begin
        wait_cyc(hold);
        serial_data <= word[i];
        wait_cyc(hold);
        serial_shift_clock <= 1'b1;
        wait_cyc(hold);
        serial_shift_clock <= 1'b0;
      end
      wait_cyc(hold);
      load_n <= 1'b1;
      wait_cyc(hold);
      serial_data <= ~serial_data;  // released line shows no stale bit
      wait_cyc(70);
      busy <= 1'b0;
    end
  end
endmodule

// ### testbench/tb.sv
// self-checking bench: serial words from the host model, status over apb
// assumes an external mux clock of 8 mclk per period once selected
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // signals
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clock_source_select = 1'b1;
  logic mux_clk_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic host_start = 1'b0;
  logic host_slow = 1'b0;
  logic [7:0] host_word = 8'h00;
  logic host_busy, serial_data, serial_shift_clock, load_n;
  logic mux_clk_out, mux_clk_oe, peak_current_full, power_down;
  logic pready, pslverr, err;
  logic [6:0] row_strobe;
  logic [39:0] column_drive, cols;
  logic [31:0] prdata, st, rd, prev;
  int bad_count = 0;
  int checked = 0;
  int len;
  int i;
  // clock and a free-running external mux clock
  initial forever #5 mclk = ~mclk;
  always begin
    repeat (4) @(posedge mclk);
    mux_clk_in <= ~mux_clk_in;
  end
  sdm_host_model host (.mclk(mclk), .start(host_start), .slow(host_slow),
    .word(host_word), .busy(host_busy), .serial_data(serial_data),
    .serial_shift_clock(serial_shift_clock), .load_n(load_n));
  sdm_display_ctrl dut (.mclk(mclk), .reset_n(reset_n),
    .serial_data(serial_data), .serial_shift_clock(serial_shift_clock),
    .load_n(load_n), .clock_source_select(clock_source_select),
    .mux_clk_in(mux_clk_in), .mux_clk_out(mux_clk_out),
    .mux_clk_oe(mux_clk_oe), .row_strobe(row_strobe),
    .column_drive(column_drive), .peak_current_full(peak_current_full),
    .power_down(power_down), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // ==========================================================
  // shared tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task field(input string what, input int lsb, input int w,
             input logic [31:0] exp);
    chk(what, exp, (st >> lsb) & ((32'h1 << w) - 32'h1));
  endtask
  // apb master: request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task rd_status();
    apb(1'b0, sdm_pkg::ADDR_STATUS, 32'h00000000);
    st = rd;
  endtask
  task send(input logic [7:0] b);
    host_word <= b;
    host_start <= 1'b1;
    @(posedge mclk);
    host_start <= 1'b0;
    @(posedge mclk);
    while (host_busy === 1'b1) begin
      @(posedge mclk);
    end
  endtask
  // catches the columns at a row 0 rise and times its on period
  task measure();
    len = 2;
    while (row_strobe[0] !== 1'b0) begin
      @(posedge mclk);
    end
    while (row_strobe[0] !== 1'b1) begin
      @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
    cols = column_drive;
    while (row_strobe[0] === 1'b1 && len < 5000) begin
      @(posedge mclk);
      len++;
    end
  endtask
  task end_of_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // watchdog, generous against about 38k cycles of tests
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
    rd_status();
    field("ctl", sdm_pkg::ST_CTL_LSB, 5,
          32'(sdm_pkg::CTL_RESET));
    field("char", sdm_pkg::ST_CHAR_LSB, 3, 32'h0);
    chk("peak", 32'h1, 32'(peak_current_full));
    chk("cols", 32'h0, 32'(column_drive[31:0]));
    chk("oe int", 32'h1, 32'(mux_clk_oe));
    // the driven clock pin must invert every half period
    prev = 32'(mux_clk_out);
    repeat (sdm_pkg::OSC_HALF_CYC) @(posedge mclk);
    chk("clk out", ~prev & 32'h1, 32'(mux_clk_out));
    clock_source_select <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("oe ext", 32'h0, 32'(mux_clk_oe));
    $display("test reset_and_source finished");
    host_slow <= 1'b1;
    send(8'hA5);
    for (i = 0; i < 8; i++) send(i == 0 ? 8'h01 : 8'h1F);
    host_slow <= 1'b0;
    rd_status();
    field("char", sdm_pkg::ST_CHAR_LSB, 3, 32'h5);
    field("rowptr", sdm_pkg::ST_ROWPTR_LSB, 3, 32'h7);
    send(8'hA2);
    send(8'h04);
    rd_status();
    field("rowptr new", sdm_pkg::ST_ROWPTR_LSB, 3, 32'h1);
    measure();
    chk("char5 row0", 32'h10, 32'(cols[29:25]));
    chk("char2 row0", 32'h04, 32'(cols[14:10]));
    chk("on 100", 32'h1, 32'(len > 2544 && len < 2576));
    $display("test ram_and_rows finished");
    for (i = 0; i < 16; i++) begin
      send(8'hE0 + 8'(i));
      rd_status();
      field("level", sdm_pkg::ST_CTL_LSB, 4, 32'(i));
      chk("peak", 32'(i / 8), 32'(peak_current_full));
      chk("pdown", 32'(i == 15), 32'(power_down));
    end
    send(8'hA1);
    send(8'h1F);
    rd_status();
    field("rowptr pd", sdm_pkg::ST_ROWPTR_LSB, 3, 32'h1);
    send(8'hE4);
    chk("wake", 32'h0, 32'(power_down));
    measure();
    chk("on 20", 32'h1, 32'(len > 496 && len < 528));
    send(8'hF0);  // prescale by 16, gates either source
    rd_status();
    field("prescale", sdm_pkg::ST_CTL_LSB, 5, 32'h10);
    send(8'hE8);
    $display("test control_words finished");
    rd_status();
    prev = st;
    send(8'h60);
    send(8'hA8);
    rd_status();
    chk("undefined", prev, st);
    send(8'hC0);
    rd_status();
    field("clr char", sdm_pkg::ST_CHAR_LSB, 3, 32'h0);
    field("clr act", sdm_pkg::ST_CLEAR_BIT, 1, 32'h1);
    field("clr ctl", sdm_pkg::ST_CTL_LSB, 5, 32'h08);
    chk("clr cols", 32'h0, column_drive[31:0]);
    send(8'h60);
    chk("ram clr", 32'h0, 32'(|column_drive));
    rd_status();
    field("clr end", sdm_pkg::ST_CLEAR_BIT, 1, 32'h0);
    $display("test clear_and_ignore finished");
    apb(1'b1, sdm_pkg::ADDR_CMD, 32'h000000A3);
    rd_status();
    field("apb char", sdm_pkg::ST_CHAR_LSB, 3, 32'h3);
    apb(1'b0, sdm_pkg::ADDR_CMD, 32'h00000000);
    chk("last cmd", 32'hA3, rd & 32'h000000FF);
    apb(1'b0, 12'h008, 32'h00000000);
    chk("unmapped", 32'h1, 32'(err));
    $display("test apb_access finished");
    end_of_test();
  end
endmodule
